// ===== fsr_pkg.sv
`default_nettype none
package fsr_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 20;
	// Bit positions inside the status byte
	localparam int POLL_BIT = 7;
	localparam int TOGGLE1_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	localparam int TOGGLE2_BIT = 2;
	localparam logic [7:0] RESET_CMD = 8'hF0;
	// Bus timing at 100 MHz
	localparam int CLK_NS = 10;
	localparam int READ_STROBE_NS = 200;
	localparam int READ_CYC = (READ_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WRITE_STROBE_NS = 100;
	localparam int WRITE_CYC = (WRITE_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_NS = 30;
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 8;
	localparam logic [1:0] RES_OK = 2'h0;
	localparam logic [1:0] RES_FAIL = 2'h1;
	typedef enum {ST_IDLE, ST_RD, ST_GAP, ST_EVAL, ST_WR, ST_DONE} fsr_state_t;
endpackage
`default_nettype wire

// ===== fsr_status_host.sv
`default_nettype none
module fsr_status_host (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// User side
	input wire logic start,
	input wire logic usePoll,
	input wire logic [fsr_pkg::ADDR_W-1:0] statAddr,
	input wire logic [fsr_pkg::DATA_W-1:0] expData,
	output logic busy,
	output logic done,
	output logic [1:0] result,
	output logic [fsr_pkg::DATA_W-1:0] finalData,
	output logic eraseSuspended,
	output logic sectorSelected,
	// Flash pins
	output logic flashCeN,
	output logic flashOeN,
	output logic flashWeN,
	output logic [fsr_pkg::ADDR_W-1:0] flashAddr,
	input wire logic [fsr_pkg::DATA_W-1:0] flashDqIn,
	output logic [fsr_pkg::DATA_W-1:0] flashDqOut,
	output logic flashDqOe,
	input wire logic ready_busy_n
);
	// Reset leaves in step with the clock, two edges late
	logic rstMeta, rstSync;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	fsr_pkg::fsr_state_t state;
	logic [fsr_pkg::CNT_W-1:0] cnt;
	logic [fsr_pkg::DATA_W-1:0] prevByte, curByte;
	// Reads taken: 1, then 2 once comparable, 3 when armed after a poll flip
	logic [1:0] nReads;
	logic sawTimeout, wantPoll;
	logic [fsr_pkg::DATA_W-1:0] pollExp;

	// Compare helpers on the byte captured in the last two reads
	logic tog1Moving, tog2Moving, pollTrue, failBit, rdEnd;
	always_comb begin
		rdEnd = state == fsr_pkg::ST_RD && cnt == fsr_pkg::CNT_W'(fsr_pkg::READ_CYC - 1);
		tog1Moving = prevByte[fsr_pkg::TOGGLE1_BIT] != curByte[fsr_pkg::TOGGLE1_BIT];
		tog2Moving = prevByte[fsr_pkg::TOGGLE2_BIT] != curByte[fsr_pkg::TOGGLE2_BIT];
		pollTrue = curByte[fsr_pkg::POLL_BIT] == pollExp[fsr_pkg::POLL_BIT];
		failBit = curByte[fsr_pkg::TIMEOUT_BIT];
	end

	// Capture at the last cycle of each strobe, while the device still drives
	always_ff @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			prevByte <= '0;
			curByte <= '0;
		end else if (rdEnd) begin
			prevByte <= curByte;
			curByte <= flashDqIn;
		end
	end

	always_ff @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			state <= fsr_pkg::ST_IDLE;
			cnt <= '0;
			nReads <= 2'h0;
			sawTimeout <= 1'b0;
			wantPoll <= 1'b0;
			pollExp <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			result <= fsr_pkg::RES_OK;
			finalData <= '0;
			eraseSuspended <= 1'b0;
			sectorSelected <= 1'b0;
			flashCeN <= 1'b1;
			flashOeN <= 1'b1;
			flashWeN <= 1'b1;
			flashAddr <= '0;
			flashDqOut <= '0;
			flashDqOe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				fsr_pkg::ST_IDLE: begin
					// Caller waits past the final write strobe before start
					if (start) begin
						busy <= 1'b1;
						wantPoll <= usePoll;
						pollExp <= expData;
						// Program address or erasing-sector address
						flashAddr <= statAddr;
						nReads <= 2'h0;
						sawTimeout <= 1'b0;
						cnt <= '0;
						flashCeN <= 1'b0;
						flashOeN <= 1'b0;
						state <= fsr_pkg::ST_RD;
					end
				end

				fsr_pkg::ST_RD: begin
					// Each read is framed by a full strobe so the device toggles
					if (rdEnd) begin
						flashCeN <= 1'b1;
						flashOeN <= 1'b1;
						cnt <= '0;
						// Stops at 2; only a poll flip arms 3, so the flip byte is never reported
						if (nReads < 2'h2)
							nReads <= nReads + 2'h1;
						state <= fsr_pkg::ST_GAP;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end

				fsr_pkg::ST_GAP: begin
					// Gap lets the device release the data bus
					if (cnt == fsr_pkg::CNT_W'(fsr_pkg::GAP_CYC - 1)) begin
						cnt <= '0;
						state <= fsr_pkg::ST_EVAL;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end

				fsr_pkg::ST_EVAL: begin
					state <= fsr_pkg::ST_RD;
					flashCeN <= 1'b0;
					flashOeN <= 1'b0;
					if (nReads == 2'h1) begin
						// Need a second read before comparing
					end else if (wantPoll ? pollTrue : !tog1Moving) begin
						// Finished; in poll mode this read follows the flip, so the byte is whole
						if (!wantPoll || nReads == 2'h3) begin
							finalData <= curByte;
							result <= fsr_pkg::RES_OK;
							// Toggle2 still moving while toggle1 stopped: suspended
							eraseSuspended <= tog2Moving;
							sectorSelected <= tog2Moving;
							flashCeN <= 1'b1;
							flashOeN <= 1'b1;
							busy <= 1'b0;
							done <= 1'b1;
							state <= fsr_pkg::ST_IDLE;
						end else begin
							// Armed: the next read gives the whole byte
							nReads <= 2'h3;
						end
					end else if (sawTimeout) begin
						// Still moving after a timeout: failed, leave via reset
						flashCeN <= 1'b0;
						flashOeN <= 1'b1;
						flashWeN <= 1'b0;
						flashDqOut <= fsr_pkg::RESET_CMD;
						flashDqOe <= 1'b1;
						cnt <= '0;
						state <= fsr_pkg::ST_WR;
					end else if (failBit) begin
						sawTimeout <= 1'b1;
					end
				end

				fsr_pkg::ST_WR: begin
					// Data stands on the bus across the whole write strobe
					if (cnt == fsr_pkg::CNT_W'(fsr_pkg::WRITE_CYC - 1)) begin
						flashWeN <= 1'b1;
						flashCeN <= 1'b1;
						cnt <= '0;
						state <= fsr_pkg::ST_DONE;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end

				fsr_pkg::ST_DONE: begin
					// Keep driving past the rising strobe for data hold
					if (cnt == fsr_pkg::CNT_W'(fsr_pkg::GAP_CYC - 1)) begin
						flashDqOe <= 1'b0;
						result <= fsr_pkg::RES_FAIL;
						finalData <= curByte;
						eraseSuspended <= 1'b0;
						sectorSelected <= 1'b0;
						busy <= 1'b0;
						done <= 1'b1;
						cnt <= '0;
						state <= fsr_pkg::ST_IDLE;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				default: state <= fsr_pkg::ST_IDLE;
			endcase
		end
	end
	// ready_busy_n is informational only; polling decides completion
endmodule
`default_nettype wire

// ===== fsr_flash_model.sv
`default_nettype none
module fsr_flash_model (
	input wire logic flashCeN, flashOeN, flashWeN, input wire logic [7:0] flashDqOut,
	output logic [7:0] flashDqIn, output logic ready_busy_n);
	timeunit 1ns;
	timeprecision 1ps;
	int left = 0;
	logic erase = 1'h0, susp = 1'h0, tmo = 1'h0, t1 = 1'h0, t2 = 1'h0;
	logic [7:0] dat = 8'h0, last = 8'h0, cur;
	wire logic rd = !flashCeN && !flashOeN, act = left > 0;
	wire logic wr = !flashCeN && !flashWeN;
	assign ready_busy_n = !act;
	assign cur = act || susp ?
		{susp | ~erase & ~dat[7], t1, tmo, 2'h0, t2, 2'h0} : dat;
	// Released bus reads inverted, so a stale byte never passes
	assign flashDqIn = rd ? cur : ~last;
	always @(negedge rd) begin
		last <= cur;
		t1 <= t1 ^ act;
		t2 <= t2 ^ (act & erase | susp);
		left <= left - int'(act & ~tmo);
	end
	// Data latches as the first of the two strobes rises
	always @(negedge wr)
		if (flashDqOut == 8'hF0)
			left <= 0;
endmodule
`default_nettype wire

// ===== fsr_sva.sv
`default_nettype none
module fsr_sva (
	input wire logic mclk, rst_n, start, busy, done, flashOeN, flashWeN, flashDqOe,
	input wire logic [1:0] result, input wire logic [7:0] flashDqOut,
	input wire logic [19:0] statAddr, flashAddr);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic wr;
	logic [19:0] addrHeld;
	// Address as taken with the request; the user may change it afterwards
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			addrHeld <= 20'h00000;
		else if (start && !busy)
			addrHeld <= statAddr;
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			wr <= 1'h0;
		else
			wr <= !flashWeN || (wr && !(start && !busy));
	sequence rdLow;
		!flashOeN [*8];
	endsequence
	a_rd_addr: assert property (!flashOeN |-> flashAddr == addrHeld)
		else $error("addr");
	a_rd_len: assert property ($fell(flashOeN) |-> rdLow)
		else $error("short read");
	a_rst_byte: assert property (!flashWeN |-> flashDqOe && flashDqOut == 8'hF0)
		else $error("reset byte");
	a_fail_rst: assert property (done && result == 2'h1 |-> wr)
		else $error("no reset");
	a_ok_quiet: assert property (done && result == 2'h0 |-> !wr)
		else $error("stray reset");
	a_idle_bus: assert property (!busy |-> flashOeN && flashWeN)
		else $error("idle bus");
endmodule
bind fsr_status_host fsr_sva chk_u (.mclk, .rst_n, .start, .busy, .done, .flashOeN, .flashWeN,
	.flashDqOe, .result, .flashDqOut, .statAddr, .flashAddr);
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0, rst_n = 1'h0, start = 1'h0, usePoll = 1'h0, ready_busy_n;
	logic busy, done, eraseSuspended, sectorSelected, flashCeN, flashOeN, flashWeN, flashDqOe;
	logic [1:0] result;
	logic [19:0] statAddr = 20'h1, flashAddr;
	logic [7:0] expData = 8'h0, finalData, flashDqOut, flashDqIn;
	int err_total = 0, checks = 0, n;
	localparam int WAIT_MAX = 12000;
	fsr_status_host dut_u (.mclk, .rst_n, .start, .usePoll, .statAddr, .expData, .busy,
		.done, .result, .finalData, .eraseSuspended, .sectorSelected, .flashCeN, .flashOeN,
		.flashWeN, .flashAddr, .flashDqIn, .flashDqOut, .flashDqOe, .ready_busy_n);
	fsr_flash_model fm (.flashCeN, .flashOeN, .flashWeN, .flashDqOut, .flashDqIn, .ready_busy_n);
	initial forever #5 mclk = ~mclk;
	task automatic cmp(input string nm, input logic [15:0] e, g);
		checks++;
		err_total += int'(g !== e);
		if (g !== e)
			$display("[FAIL] %s exp %h got %h", nm, e, g);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic go(input logic p, input logic [7:0] d, input int b, input logic [2:0] f);
		{fm.erase, fm.susp, fm.tmo, fm.dat} = {f, d};
		fm.left = b;
		@(posedge mclk);
		{usePoll, expData, start} <= {p, d, 1'h1};
		statAddr <= statAddr + 20'h12345;
		@(posedge mclk);
		start <= 1'h0;
		for (n = 0; n < WAIT_MAX && done !== 1'h1; n++)
			@(posedge mclk) #1;
		err_total += int'(n == WAIT_MAX);
		if (n == WAIT_MAX)
			tally_and_finish;
	endtask
	task automatic poll_prog;
		go(1'h1, 8'hA5, 3, 3'h0);
		cmp("poll", 16'h00A5, {6'h00, result, finalData});
	endtask
	task automatic erase_susp;
		go(1'h0, 8'hFF, 0, 3'h6);
		cmp("susp", 16'h0003, {6'h00, result, 6'h00, eraseSuspended, sectorSelected});
	endtask
	task automatic timeout_fail;
		go(1'h0, 8'hFF, 2, 3'h1);
		cmp("tmo", 16'h0101, {6'h00, result, 7'h00, ready_busy_n});
		go(1'h1, 8'hA5, 2, 3'h1);
		cmp("tmo_poll", 16'h0101, {6'h00, result, 7'h00, ready_busy_n});
	endtask
	// Protected target: status runs for a fixed time, then the old byte reads back
	task automatic protect_run(input logic [2:0] f, input int ns);
		fork
			#(ns) fm.left = 0;
		join_none
		go(1'h0, 8'h3C, 1000000, f);
		cmp("prot", 16'h003C, {6'h00, result, finalData});
		cmp("prot_len", 16'h0001, {15'h0000, n + 2 >= ns / 10 && n <= ns / 10 + 80});
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (4) @(posedge mclk);
		poll_prog;
		erase_susp;
		timeout_fail;
		protect_run(3'h0, 1000);
		protect_run(3'h4, 100000);
		tally_and_finish;
	end
endmodule
`default_nettype wire
